// ---- core/tmr_pkg.sv ----
package tmr_pkg;
	localparam logic [7:0] TMR_OFF_FLAGS = 8'h37;
	localparam logic [7:0] TMR_OFF_MASK = 8'h70;
	localparam logic [7:0] TMR_OFF_CTRL_A = 8'hB0;
	localparam logic [7:0] TMR_OFF_CTRL_B = 8'hB1;
	localparam logic [7:0] TMR_OFF_COUNT = 8'hB2;
	localparam logic [7:0] TMR_OFF_CMP_A = 8'hB3;
	localparam logic [7:0] TMR_OFF_CMP_B = 8'hB4;
	localparam logic [7:0] TMR_OFF_ASYNC = 8'hB6;
	localparam logic [7:0] TMR_RST_VAL = 8'h00;
	localparam int TMR_BIT_WRAP = 0;
	localparam int TMR_BIT_MA = 1;
	localparam int TMR_BIT_MB = 2;
	localparam int TMR_BIT_FOC_A = 7;
	localparam int TMR_BIT_FOC_B = 6;
	localparam int TMR_BIT_WAVE_MODE_SEL = 3;
	localparam int TMR_BIT_EXT_CLK_INPUT_EN = 6;
	localparam int TMR_BIT_AS2 = 5;
	localparam logic [7:0] TMR_MAX = 8'hFF;
	localparam logic [7:0] TMR_BOTTOM = 8'h00;
	localparam logic [2:0] TMR_WM_NORMAL = 3'h0;
	localparam logic [2:0] TMR_WM_PC_FF = 3'h1;
	localparam logic [2:0] TMR_WM_CTC = 3'h2;
	localparam logic [2:0] TMR_WM_FAST_FF = 3'h3;
	localparam logic [2:0] TMR_WM_PC_A = 3'h5;
	localparam logic [2:0] TMR_WM_FAST_A = 3'h7;
	localparam logic [9:0] TMR_PRE_MAX = 10'h3FF;
	localparam int TMR_UPD_CYCLES = 2;
endpackage

// ---- core/tmr_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr_ctrl
	import tmr_pkg::*;
#(
	parameter int UPD_CYCLES = TMR_UPD_CYCLES
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic global_irq_en,
	input wire logic [2:0] irq_ack,
	input wire logic osc_in_pin,
	output logic wave_out_a,
	output logic wave_out_b,
	output logic irq_wrap,
	output logic irq_match_a,
	output logic irq_match_b
);
	// ***************************************
	// State
	// ***************************************
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [3:0] ctrl_b;
		logic [7:0] count;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [2:0] mask;
		logic [2:0] flags;
		logic [1:0] async_cfg;
		logic [4:0] busy;
		logic [7:0] busy_cnt;
		logic [9:0] pre;
		logic osc_q;
		logic down;
		logic block;
		logic oa;
		logic ob;
		logic [7:0] rdata;
		logic [2:0] irq;
	} tmr_state_t;

	tmr_state_t s_r, s_nxt;

	function automatic logic is_pwm(input logic [2:0] wm);
		is_pwm = (wm != TMR_WM_NORMAL) && (wm != TMR_WM_CTC);
	endfunction

	function automatic logic com_apply(input logic [1:0] com, input logic cur);
		unique case (com)
			2'b00: com_apply = cur;
			2'b01: com_apply = ~cur;
			2'b10: com_apply = 1'b0;
			2'b11: com_apply = 1'b1;
		endcase
	endfunction

	function automatic logic pc_apply(input logic [1:0] com, input logic dn, input logic tg,
		input logic cur);
		pc_apply = com[1] ? (com[0] ^ dn) : ((com[0] && tg) ? ~cur : cur);
	endfunction

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
		wr_hit = w && (a == off);
	endfunction

	logic [2:0] wm, cs;
	logic [7:0] top;
	logic tick, ext_edge, m_a, m_b, wrap_ev;
	logic pc_mode, fast_mode, force_a, force_b, async_on;

	assign wm = {s_r.ctrl_b[TMR_BIT_WAVE_MODE_SEL], s_r.ctrl_a[1:0]};
	assign cs = s_r.ctrl_b[2:0];
	assign async_on = s_r.async_cfg[0];
	assign pc_mode = (wm == TMR_WM_PC_FF) || (wm == TMR_WM_PC_A);
	assign fast_mode = (wm == TMR_WM_FAST_FF) || (wm == TMR_WM_FAST_A);
	assign top = (wm == TMR_WM_CTC || wm == TMR_WM_PC_A || wm == TMR_WM_FAST_A) ?
		s_r.cmp_a : TMR_MAX;
	// Oscillator pin taken as a plain sampled input; rising edge is one count
	assign ext_edge = osc_in_pin && !s_r.osc_q;

	// ***************************************
	// Next state
	// ***************************************
	always_comb
	begin
		s_nxt = s_r;
		tick = 1'b0;
		m_a = 1'b0;
		m_b = 1'b0;
		wrap_ev = 1'b0;
		force_a = 1'b0;
		force_b = 1'b0;
		s_nxt.osc_q = osc_in_pin;
		s_nxt.pre = s_r.pre + 10'h001;
		unique case (cs)
			3'h0: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = (s_r.pre[2:0] == TMR_PRE_MAX[2:0]);
			3'h3: tick = (s_r.pre[4:0] == TMR_PRE_MAX[4:0]);
			3'h4: tick = (s_r.pre[5:0] == TMR_PRE_MAX[5:0]);
			3'h5: tick = (s_r.pre[6:0] == TMR_PRE_MAX[6:0]);
			3'h6: tick = (s_r.pre[7:0] == TMR_PRE_MAX[7:0]);
			3'h7: tick = (s_r.pre == TMR_PRE_MAX);
		endcase
		if (async_on)
			tick = (cs != 3'h0) && ext_edge;
		// Counter and compare
		if (tick)
		begin
			m_a = (s_r.count == s_r.cmp_a) && !s_r.block;
			m_b = (s_r.count == s_r.cmp_b) && !s_r.block;
			s_nxt.block = 1'b0;
			if (pc_mode)
			begin
				if (!s_r.down && s_r.count == top)
				begin
					s_nxt.down = 1'b1;
					s_nxt.count = s_r.count - 8'h01;
				end
				else if (s_r.down && s_r.count == TMR_BOTTOM)
				begin
					s_nxt.down = 1'b0;
					s_nxt.count = s_r.count + 8'h01;
					wrap_ev = 1'b1;
				end
				else
					s_nxt.count = s_r.down ? s_r.count - 8'h01 : s_r.count + 8'h01;
			end
			else
			begin
				s_nxt.down = 1'b0;
				if (s_r.count == top)
				begin
					s_nxt.count = TMR_BOTTOM;
					wrap_ev = (wm == TMR_WM_FAST_A) || (s_r.count == TMR_MAX);
				end
				else
					s_nxt.count = s_r.count + 8'h01;
			end
		end
		// Waveforms from real matches and from top in fast modes
		if (m_a)
			s_nxt.oa = pc_mode ? pc_apply(s_r.ctrl_a[7:6], s_r.down, wm[2], s_r.oa) :
				com_apply(s_r.ctrl_a[7:6], s_r.oa);
		if (m_b)
			s_nxt.ob = pc_mode ? pc_apply(s_r.ctrl_a[5:4], s_r.down, 1'b0, s_r.ob) :
				com_apply(s_r.ctrl_a[5:4], s_r.ob);
		if (fast_mode && tick && s_r.count == top)
		begin
			if (s_r.ctrl_a[7])
				s_nxt.oa = ~s_r.ctrl_a[6];
			if (s_r.ctrl_a[5])
				s_nxt.ob = ~s_r.ctrl_a[4];
		end
		// Busy drops a fixed delay after the last write; a new write wins the tie
		if (s_r.busy != 5'h00)
			s_nxt.busy_cnt = s_r.busy_cnt + 8'h01;
		if (s_r.busy != 5'h00 && s_r.busy_cnt == 8'(UPD_CYCLES - 1))
			s_nxt.busy = 5'h00;
		if (bus_wr && (bus_addr inside {TMR_OFF_COUNT, TMR_OFF_CMP_A, TMR_OFF_CMP_B,
			TMR_OFF_CTRL_A, TMR_OFF_CTRL_B}))
			s_nxt.busy_cnt = 8'h00;
		// Register writes; flags: hardware set beats software clear
		if (wr_hit(bus_addr, TMR_OFF_CTRL_A, bus_wr))
		begin
			s_nxt.ctrl_a = bus_wdata;
			s_nxt.busy[1] = async_on;
		end
		if (wr_hit(bus_addr, TMR_OFF_CTRL_B, bus_wr))
		begin
			s_nxt.ctrl_b = {bus_wdata[TMR_BIT_WAVE_MODE_SEL], bus_wdata[2:0]};
			s_nxt.busy[0] = async_on;
			// Strobes never stored, so they read back zero
			force_a = bus_wdata[TMR_BIT_FOC_A] && !is_pwm(wm);
			force_b = bus_wdata[TMR_BIT_FOC_B] && !is_pwm(wm);
		end
		// Forced match drives output only, no flag, no clear
		if (force_a)
			s_nxt.oa = com_apply(s_r.ctrl_a[7:6], s_r.oa);
		if (force_b)
			s_nxt.ob = com_apply(s_r.ctrl_a[5:4], s_r.ob);
		if (wr_hit(bus_addr, TMR_OFF_COUNT, bus_wr))
		begin
			s_nxt.count = bus_wdata;
			s_nxt.block = 1'b1;
			s_nxt.busy[4] = async_on;
		end
		if (wr_hit(bus_addr, TMR_OFF_CMP_A, bus_wr))
		begin
			s_nxt.cmp_a = bus_wdata;
			s_nxt.busy[3] = async_on;
		end
		if (wr_hit(bus_addr, TMR_OFF_CMP_B, bus_wr))
		begin
			s_nxt.cmp_b = bus_wdata;
			s_nxt.busy[2] = async_on;
		end
		if (wr_hit(bus_addr, TMR_OFF_MASK, bus_wr))
			s_nxt.mask = bus_wdata[2:0];
		if (wr_hit(bus_addr, TMR_OFF_ASYNC, bus_wr))
			s_nxt.async_cfg = {bus_wdata[TMR_BIT_EXT_CLK_INPUT_EN], bus_wdata[TMR_BIT_AS2]};
		if (wr_hit(bus_addr, TMR_OFF_FLAGS, bus_wr))
			s_nxt.flags = s_r.flags & ~bus_wdata[2:0];
		s_nxt.flags = s_nxt.flags & ~irq_ack;
		s_nxt.flags[TMR_BIT_MA] = s_nxt.flags[TMR_BIT_MA] | m_a;
		s_nxt.flags[TMR_BIT_MB] = s_nxt.flags[TMR_BIT_MB] | m_b;
		s_nxt.flags[TMR_BIT_WRAP] = s_nxt.flags[TMR_BIT_WRAP] | wrap_ev;
		// Read data, unmapped reads zero
		s_nxt.rdata = 8'h00;
		if (bus_rd)
		begin
			unique case (bus_addr)
				TMR_OFF_FLAGS: s_nxt.rdata = {5'h00, s_r.flags};
				TMR_OFF_MASK: s_nxt.rdata = {5'h00, s_r.mask};
				TMR_OFF_CTRL_A: s_nxt.rdata = s_r.ctrl_a;
				TMR_OFF_CTRL_B: s_nxt.rdata = {4'h0, s_r.ctrl_b};
				TMR_OFF_COUNT: s_nxt.rdata = s_r.count;
				TMR_OFF_CMP_A: s_nxt.rdata = s_r.cmp_a;
				TMR_OFF_CMP_B: s_nxt.rdata = s_r.cmp_b;
				TMR_OFF_ASYNC: s_nxt.rdata = {1'b0, s_r.async_cfg, s_r.busy};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		s_nxt.irq = s_nxt.flags & s_nxt.mask & {3{global_irq_en}};
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign wave_out_a = s_r.oa;
	assign wave_out_b = s_r.ob;
	assign bus_rdata = s_r.rdata;
	assign irq_wrap = s_r.irq[TMR_BIT_WRAP];
	assign irq_match_a = s_r.irq[TMR_BIT_MA];
	assign irq_match_b = s_r.irq[TMR_BIT_MB];

	// ***************************************
	// Checks
	// ***************************************
	property p_irq_and;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> (irq_match_a == ($past(s_nxt.flags[TMR_BIT_MA]) &&
			$past(s_nxt.mask[TMR_BIT_MA]) && $past(global_irq_en)));
	endproperty
	a_irq_and: assert property (p_irq_and) else $error("irq a not flag and mask");

	property p_w1c;
		@(posedge clk) disable iff (!reset_n)
		(wr_hit(bus_addr, TMR_OFF_FLAGS, bus_wr) && bus_wdata[0] && !wrap_ev)
		|=> !s_r.flags[0];
	endproperty
	a_w1c: assert property (p_w1c) else $error("wrap flag not cleared");

	property p_w0_keep;
		@(posedge clk) disable iff (!reset_n)
		(wr_hit(bus_addr, TMR_OFF_FLAGS, bus_wr) && !bus_wdata[1] && s_r.flags[1] &&
			!irq_ack[1]) |=> s_r.flags[1];
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");

	property p_ack;
		@(posedge clk) disable iff (!reset_n)
		(irq_ack[2] && !m_b) |=> !s_r.flags[2];
	endproperty
	a_ack: assert property (p_ack) else $error("ack did not clear flag");

	property p_match_flag;
		@(posedge clk) disable iff (!reset_n)
		m_a |=> s_r.flags[1];
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match a flag missing");

	property p_force_noflag;
		@(posedge clk) disable iff (!reset_n)
		(force_b && !m_b && !s_r.flags[2]) |=> !s_r.flags[2];
	endproperty
	a_force_noflag: assert property (p_force_noflag) else $error("force set flag");

	property p_pwm_ignore;
		@(posedge clk) disable iff (!reset_n)
		is_pwm(wm) |-> !force_a && !force_b;
	endproperty
	a_pwm_ignore: assert property (p_pwm_ignore) else $error("force in pwm");

	property p_block;
		@(posedge clk) disable iff (!reset_n)
		wr_hit(bus_addr, TMR_OFF_COUNT, bus_wr) |=> (tick -> !m_a && !m_b);
	endproperty
	a_block: assert property (p_block) else $error("match after count write");

	property p_stop;
		@(posedge clk) disable iff (!reset_n)
		(cs == 3'h0 && !bus_wr) |=> s_r.count == $past(s_r.count);
	endproperty
	a_stop: assert property (p_stop) else $error("counter ran while stopped");

	property p_rd_zero;
		@(posedge clk) disable iff (!reset_n)
		(bus_rd && bus_addr == TMR_OFF_CTRL_B) |=> bus_rdata[7:6] == 2'b00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("force bits read nonzero");
endmodule // tmr_ctrl
`default_nettype wire

// ---- verification/test_tmr_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Timer control bench
// ****************
module test_tmr_ctrl;
	import tmr_pkg::*;
	// Longer busy window so a read can land inside it
	localparam int UPD = 6;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic global_irq_en = 1'b0;
	logic osc_in_pin = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] rd_val;
	logic [2:0] irq_ack = 3'h0;
	logic [7:0] bus_rdata;
	logic wave_out_a, wave_out_b, irq_wrap, irq_match_a, irq_match_b;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;

	always #25 clk = ~clk;

	tmr_ctrl #(.UPD_CYCLES(UPD)) tmr_ctrl_inst (.clk(clk), .reset_n(reset_n),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
		.osc_in_pin(osc_in_pin), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.irq_wrap(irq_wrap), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b));

	// ****************
	// Bus and compare tasks
	// ****************
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Unknown fails too: the relation must be exactly one
	task automatic chk_rng(input string nm, input logic [7:0] lo, hi, got);
		total_checks++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			err_total++;
			$display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
		end
	endtask

	task automatic cyc_n(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc_n(1);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		cyc_n(1);
		bus_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		cyc_n(1);
		bus_addr = a;
		bus_rd = 1'b1;
		cyc_n(1);
		bus_rd = 1'b0;
		rd_val = bus_rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk8($sformatf("reg %h", a), e, rd_val);
	endtask

	task automatic ack(input logic [2:0] v);
		cyc_n(1);
		irq_ack = v;
		cyc_n(1);
		irq_ack = 3'h0;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		logic [7:0] offs [9] = '{TMR_OFF_FLAGS, TMR_OFF_MASK, TMR_OFF_CTRL_A, TMR_OFF_CTRL_B,
			TMR_OFF_COUNT, TMR_OFF_CMP_A, TMR_OFF_CMP_B, TMR_OFF_ASYNC, 8'h50};
		foreach (offs[i]) rchk(offs[i], TMR_RST_VAL);
	endtask

	task automatic t_force();
		wr(TMR_OFF_CMP_A, 8'h80);
		wr(TMR_OFF_CMP_B, 8'h90);
		wr(TMR_OFF_CTRL_A, 8'h50);
		wr(TMR_OFF_FLAGS, 8'h07);
		wr(TMR_OFF_CTRL_B, 8'hC0);
		cyc_n(2);
		chk8("wave_out_a", 8'h01, {7'h00, wave_out_a});
		chk8("wave_out_b", 8'h01, {7'h00, wave_out_b});
		rchk(TMR_OFF_CTRL_B, 8'h00);
		rchk(TMR_OFF_FLAGS, 8'h00);
		wr(TMR_OFF_CTRL_A, 8'h51);
		wr(TMR_OFF_CTRL_B, 8'h00);
		wr(TMR_OFF_CTRL_B, 8'hC0);
		cyc_n(2);
		chk8("wave_out_a", 8'h01, {7'h00, wave_out_a});
		chk8("wave_out_b", 8'h01, {7'h00, wave_out_b});
		wr(TMR_OFF_CTRL_B, 8'h00);
		wr(TMR_OFF_CTRL_A, 8'h00);
	endtask

	task automatic t_match();
		wr(TMR_OFF_CMP_A, 8'h05);
		wr(TMR_OFF_CMP_B, 8'h09);
		wr(TMR_OFF_MASK, 8'h06);
		wr(TMR_OFF_COUNT, 8'h00);
		wr(TMR_OFF_FLAGS, 8'h07);
		global_irq_en = 1'b1;
		wr(TMR_OFF_CTRL_B, 8'h01);
		cyc_n(12);
		wr(TMR_OFF_CTRL_B, 8'h00);
		rchk(TMR_OFF_FLAGS, 8'h06);
		chk8("irq_match_a", 8'h01, {7'h00, irq_match_a});
		chk8("irq_match_b", 8'h01, {7'h00, irq_match_b});
		chk8("irq_wrap", 8'h00, {7'h00, irq_wrap});
		global_irq_en = 1'b0;
		cyc_n(2);
		chk8("irq_match_a", 8'h00, {7'h00, irq_match_a});
		global_irq_en = 1'b1;
		wr(TMR_OFF_FLAGS, 8'h02);
		rchk(TMR_OFF_FLAGS, 8'h04);
		chk8("irq_match_a", 8'h00, {7'h00, irq_match_a});
		chk8("irq_match_b", 8'h01, {7'h00, irq_match_b});
		ack(3'h4);
		rchk(TMR_OFF_FLAGS, 8'h00);
	endtask

	task automatic t_wrap();
		wr(TMR_OFF_MASK, 8'h01);
		wr(TMR_OFF_COUNT, 8'hFE);
		wr(TMR_OFF_CTRL_B, 8'h01);
		cyc_n(2);
		wr(TMR_OFF_CTRL_B, 8'h00);
		rchk(TMR_OFF_FLAGS, 8'h01);
		chk8("irq_wrap", 8'h01, {7'h00, irq_wrap});
		ack(3'h1);
		rchk(TMR_OFF_FLAGS, 8'h00);
		wr(TMR_OFF_COUNT, 8'h00);
		wr(TMR_OFF_CTRL_B, 8'h01);
		wr(TMR_OFF_COUNT, 8'h05);
		wr(TMR_OFF_CTRL_B, 8'h00);
		rchk(TMR_OFF_FLAGS, 8'h00);
	endtask

	task automatic t_presc();
		int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
		for (int c = 0; c < 8; c++)
		begin
			wr(TMR_OFF_COUNT, 8'h00);
			wr(TMR_OFF_CTRL_B, 8'(c));
			cyc_n(c == 0 ? 20 : 4 * dv[c]);
			wr(TMR_OFF_CTRL_B, 8'h00);
			rd(TMR_OFF_COUNT);
			chk_rng("count", c == 0 ? 8'h00 : 8'h03, c == 0 ? 8'h00 : 8'h06, rd_val);
		end
	endtask

	task automatic t_modes();
		// Clear-on-match: top from compare A; forced match leaves count alone
		wr(TMR_OFF_CMP_A, 8'h03);
		wr(TMR_OFF_CTRL_A, 8'h02);
		wr(TMR_OFF_COUNT, 8'h00);
		wr(TMR_OFF_FLAGS, 8'h07);
		wr(TMR_OFF_CTRL_B, 8'h01);
		cyc_n(4);
		wr(TMR_OFF_CTRL_B, 8'h00);
		rchk(TMR_OFF_COUNT, 8'h02);
		rchk(TMR_OFF_FLAGS, 8'h02);
		wr(TMR_OFF_FLAGS, 8'h07);
		wr(TMR_OFF_CTRL_B, 8'hC0);
		rchk(TMR_OFF_COUNT, 8'h02);
		rchk(TMR_OFF_FLAGS, 8'h00);
		// Phase-correct, top from compare A, clear on up-count match
		wr(TMR_OFF_CMP_A, 8'h04);
		wr(TMR_OFF_COUNT, 8'h00);
		wr(TMR_OFF_FLAGS, 8'h07);
		wr(TMR_OFF_CTRL_A, 8'h81);
		wr(TMR_OFF_CTRL_B, 8'h09);
		cyc_n(3);
		wr(TMR_OFF_CTRL_B, 8'h08);
		rchk(TMR_OFF_COUNT, 8'h03);
		rchk(TMR_OFF_FLAGS, 8'h02);
		chk8("wave_out_a", 8'h00, {7'h00, wave_out_a});
		wr(TMR_OFF_CTRL_B, 8'h09);
		cyc_n(2);
		wr(TMR_OFF_CTRL_B, 8'h08);
		rchk(TMR_OFF_COUNT, 8'h01);
		rchk(TMR_OFF_FLAGS, 8'h03);
		chk8("irq_wrap", 8'h01, {7'h00, irq_wrap});
		wr(TMR_OFF_FLAGS, 8'h07);
		wr(TMR_OFF_CTRL_B, 8'h00);
		wr(TMR_OFF_CTRL_A, 8'h00);
	endtask

	task automatic t_async();
		wr(TMR_OFF_ASYNC, 8'h20);
		wr(TMR_OFF_CMP_A, 8'h05);
		rchk(TMR_OFF_ASYNC, 8'h28);
		cyc_n(UPD + 4);
		rchk(TMR_OFF_ASYNC, 8'h20);
		wr(TMR_OFF_COUNT, 8'h00);
		wr(TMR_OFF_CTRL_B, 8'h01);
		cyc_n(UPD + 4);
		repeat (3)
		begin
			osc_in_pin = 1'b1;
			cyc_n(4);
			osc_in_pin = 1'b0;
			cyc_n(4);
		end
		wr(TMR_OFF_CTRL_B, 8'h00);
		cyc_n(UPD + 4);
		rd(TMR_OFF_COUNT);
		chk_rng("count", 8'h02, 8'h03, rd_val);
		wr(TMR_OFF_ASYNC, 8'h00);
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			report_and_stop();
		end
	end

	initial
	begin
		repeat (20) @(posedge clk);
		#2;
		reset_n = 1'b1;
		t_reset();
		t_force();
		t_match();
		t_wrap();
		t_presc();
		t_modes();
		t_async();
		report_and_stop();
	end
endmodule // test_tmr_ctrl
`default_nettype wire
